/* File: src/dsss_tx_pkg.sv */
package dsss_tx_pkg;

  // Register byte offsets
  localparam logic [7:0] scrambler_control_off = 8'h00;
  localparam logic [7:0] long_seed_off = 8'h04;
  localparam logic [7:0] short_seed_off = 8'h08;
  localparam logic [7:0] modem_config_off = 8'h0C;
  localparam logic [7:0] tx_setup_off = 8'h10;
  localparam logic [7:0] status_off = 8'h14;

  // Field positions
  localparam int bypass_bit = 2;
  localparam int tx_reverse_bit = 6;
  localparam int rx_reverse_bit = 7;
  localparam int short_pre_bit = 2;

  // Reset values
  localparam logic [6:0] long_seed_rst = 7'h7F;
  localparam logic [6:0] short_seed_rst = 7'h7F;
  localparam logic [1:0] rate_rst = 2'h0;

  // Scrambler taps, z^-4 and z^-7
  localparam int tap_a = 3;
  localparam int tap_b = 6;

  // Chip timing: fractional divider, clock and chip rate in kHz
  localparam int clk_khz = 250000;
  localparam int chip_khz = 11000;
  localparam int div_step = chip_khz / 1000;
  localparam int div_mod = clk_khz / 1000;

  localparam int barker_len = 11;
  localparam logic [10:0] barker_word = 11'h0ED;
  localparam int cck_len = 8;

  typedef enum logic [3:0] {
    mode_dbpsk = 4'b0001,
    mode_dqpsk = 4'b0010,
    mode_cck5 = 4'b0100,
    mode_cck11 = 4'b1000
  } sym_mode_t;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_run = 2'b10
  } tx_state_t;

  // Segment codes from the framing source
  localparam logic [1:0] seg_preamble = 2'h0;
  localparam logic [1:0] seg_header = 2'h1;
  localparam logic [1:0] seg_payload = 2'h2;

  typedef struct packed {
    logic valid;
    logic i;
    logic q;
  } chip_t;

endpackage : dsss_tx_pkg

/* File: src/dsss_scrambler_cck_modulator.sv */
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module dsss_scrambler_cck_modulator (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tx_start,
  input wire logic [1:0] tx_seg,
  input wire logic tx_bit,
  input wire logic tx_valid,
  output logic tx_ready,
  output dsss_tx_pkg::chip_t tx_chip,
  output logic tx_active,
  input wire logic rx_bit,
  input wire logic rx_valid,
  output logic rx_data,
  output logic rx_data_valid,
  output logic rx_rotate_reverse
);

  function automatic logic [1:0] gray_phase(input logic first, input logic second);
    gray_phase = {first, first ^ second};
  endfunction : gray_phase

  function automatic logic [3:0] need_bits(input dsss_tx_pkg::sym_mode_t m);
    case (m)
      dsss_tx_pkg::mode_dbpsk: need_bits = 4'h1;
      dsss_tx_pkg::mode_dqpsk: need_bits = 4'h2;
      dsss_tx_pkg::mode_cck5: need_bits = 4'h4;
      default: need_bits = 4'h8;
    endcase
  endfunction : need_bits

  function automatic logic [3:0] chip_count(input dsss_tx_pkg::sym_mode_t m);
    if (m == dsss_tx_pkg::mode_cck5 || m == dsss_tx_pkg::mode_cck11)
      chip_count = 4'(dsss_tx_pkg::cck_len);
    else
      chip_count = 4'(dsss_tx_pkg::barker_len);
  endfunction : chip_count

  // Phase in quarter turns; 0..3 map to (+,+),(-,+),(-,-),(+,-)
  function automatic logic [1:0] quad_i_q(input logic [1:0] p);
    quad_i_q = {~(p[1] ^ p[0]), ~p[1]};
  endfunction : quad_i_q

  logic scr_bypass_ff;
  logic [6:0] long_seed_ff;
  logic [6:0] short_seed_ff;
  logic tx_reverse_ff;
  logic rx_reverse_ff;
  logic [1:0] rate_ff;
  logic short_pre_ff;
  logic [6:0] scr_ff;
  logic [6:0] dscr_ff;
  logic [7:0] div_ff;
  logic chip_en_ff;
  logic [7:0] bitbuf_ff;
  logic [3:0] cnt_ff;
  dsss_tx_pkg::sym_mode_t cmode_ff;
  logic cpay_ff;
  dsss_tx_pkg::tx_state_t state_ff;
  dsss_tx_pkg::sym_mode_t smode_ff;
  logic [3:0] chip_idx_ff;
  logic [1:0] ref_ff;
  logic [1:0] phi2_ff;
  logic [1:0] phi3_ff;
  logic [1:0] phi4_ff;
  logic odd_ff;
  logic [1:0] iq_pair_ff;
  logic tx_ready_ff;
  dsss_tx_pkg::chip_t chip_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic rx_data_ff;
  logic rx_data_valid_ff;

  logic accept;
  logic scr_out;
  dsss_tx_pkg::sym_mode_t in_mode;
  dsss_tx_pkg::sym_mode_t nxt_cmode;
  logic [3:0] nxt_cnt;
  logic last_chip;
  logic load_sym;
  logic [1:0] nxt_ref;
  logic [1:0] dphi;
  logic [1:0] chip_phase;
  logic [2:0] ci;
  logic [7:0] ahb_addr;
  logic ahb_go;

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0 & hreadyout_ff;
  assign tx_ready = tx_ready_ff;
  assign tx_chip = chip_ff;
  assign tx_active = state_ff == dsss_tx_pkg::st_run;
  assign rx_data = rx_data_ff;
  assign rx_data_valid = rx_data_valid_ff;
  assign rx_rotate_reverse = rx_reverse_ff;

  // Zero wait state slave; read data is fetched during the address phase
  assign ahb_addr = haddr[7:0];
  assign ahb_go = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end
    else
    begin
      hreadyout_ff <= 1'b1;
      wr_pend_ff <= ahb_go && hwrite;
      wr_addr_ff <= ahb_addr;
      hrdata_ff <= 32'h00000000;
      if (ahb_go && !hwrite)
      begin
        if (ahb_addr == dsss_tx_pkg::scrambler_control_off)
          hrdata_ff[dsss_tx_pkg::bypass_bit] <= scr_bypass_ff;
        else if (ahb_addr == dsss_tx_pkg::long_seed_off)
          hrdata_ff[6:0] <= long_seed_ff;
        else if (ahb_addr == dsss_tx_pkg::short_seed_off)
          hrdata_ff[6:0] <= short_seed_ff;
        else if (ahb_addr == dsss_tx_pkg::modem_config_off)
        begin
          hrdata_ff[dsss_tx_pkg::tx_reverse_bit] <= tx_reverse_ff;
          hrdata_ff[dsss_tx_pkg::rx_reverse_bit] <= rx_reverse_ff;
        end
        else if (ahb_addr == dsss_tx_pkg::tx_setup_off)
          hrdata_ff[2:0] <= {short_pre_ff, rate_ff};
        else if (ahb_addr == dsss_tx_pkg::status_off)
          hrdata_ff[11:0] <= {odd_ff, scr_ff, ref_ff, cnt_ff == 4'h0, tx_active};
      end
    end
  end

  // Register writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scr_bypass_ff <= 1'b0;
      long_seed_ff <= dsss_tx_pkg::long_seed_rst;
      short_seed_ff <= dsss_tx_pkg::short_seed_rst;
      tx_reverse_ff <= 1'b0;
      rx_reverse_ff <= 1'b0;
      rate_ff <= dsss_tx_pkg::rate_rst;
      short_pre_ff <= 1'b0;
    end
    else if (wr_pend_ff)
    begin
      if (wr_addr_ff == dsss_tx_pkg::scrambler_control_off)
        scr_bypass_ff <= hwdata[dsss_tx_pkg::bypass_bit];
      else if (wr_addr_ff == dsss_tx_pkg::long_seed_off)
        long_seed_ff <= hwdata[6:0];
      else if (wr_addr_ff == dsss_tx_pkg::short_seed_off)
        short_seed_ff <= hwdata[6:0];
      else if (wr_addr_ff == dsss_tx_pkg::modem_config_off)
      begin
        tx_reverse_ff <= hwdata[dsss_tx_pkg::tx_reverse_bit];
        rx_reverse_ff <= hwdata[dsss_tx_pkg::rx_reverse_bit];
      end
      else if (wr_addr_ff == dsss_tx_pkg::tx_setup_off)
      begin
        rate_ff <= hwdata[1:0];
        short_pre_ff <= hwdata[dsss_tx_pkg::short_pre_bit];
      end
    end
  end

  // Fractional divider: 11 chip enables per 250 clocks, no drift
  // Compare at nine bits, an 8-bit sum wraps past 255 and drops enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_ff <= 8'h00;
      chip_en_ff <= 1'b0;
    end
    else if ({1'b0, div_ff} + 9'(dsss_tx_pkg::div_step) >= 9'(dsss_tx_pkg::div_mod))
    begin
      div_ff <= div_ff + 8'(dsss_tx_pkg::div_step) - 8'(dsss_tx_pkg::div_mod);
      chip_en_ff <= 1'b1;
    end
    else
    begin
      div_ff <= div_ff + 8'(dsss_tx_pkg::div_step);
      chip_en_ff <= 1'b0;
    end
  end

  // Coding follows the segment: preamble always DBPSK
  always_comb
  begin
    if (tx_seg == dsss_tx_pkg::seg_payload)
    begin
      case (rate_ff)
        2'h0: in_mode = dsss_tx_pkg::mode_dbpsk;
        2'h1: in_mode = dsss_tx_pkg::mode_dqpsk;
        2'h2: in_mode = dsss_tx_pkg::mode_cck5;
        default: in_mode = dsss_tx_pkg::mode_cck11;
      endcase
    end
    else if (tx_seg == dsss_tx_pkg::seg_header && short_pre_ff)
      in_mode = dsss_tx_pkg::mode_dqpsk;
    else
      in_mode = dsss_tx_pkg::mode_dbpsk;
  end

  assign accept = tx_valid && tx_ready_ff;
  assign scr_out = scr_bypass_ff ? tx_bit : tx_bit ^ scr_ff[dsss_tx_pkg::tap_a] ^ scr_ff[dsss_tx_pkg::tap_b];
  assign last_chip = chip_en_ff && state_ff == dsss_tx_pkg::st_run && chip_idx_ff == chip_count(smode_ff) - 4'h1;
  assign load_sym = cnt_ff != 4'h0 && cnt_ff == need_bits(cmode_ff) && (state_ff == dsss_tx_pkg::st_idle || last_chip);

  always_comb
  begin
    nxt_cmode = cmode_ff;
    nxt_cnt = load_sym ? 4'h0 : cnt_ff;
    if (accept)
    begin
      nxt_cnt = nxt_cnt + 4'h1;
      if (cnt_ff == 4'h0)
        nxt_cmode = in_mode;
    end
  end

  // Scrambler: every bit, in every segment, unless bypassed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      scr_ff <= 7'h00;
    else if (tx_start)
      scr_ff <= short_pre_ff ? short_seed_ff : long_seed_ff;
    else if (accept && !scr_bypass_ff)
      scr_ff <= {scr_ff[5:0], scr_out};
  end

  // Bit collector; a new symbol can fill while the last is on air
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bitbuf_ff <= 8'h00;
      cnt_ff <= 4'h0;
      cmode_ff <= dsss_tx_pkg::mode_dbpsk;
      cpay_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      cmode_ff <= nxt_cmode;
      if (accept)
        bitbuf_ff[3'(cnt_ff)] <= scr_out;
      if (accept && cnt_ff == 4'h0)
        cpay_ff <= tx_seg == dsss_tx_pkg::seg_payload;
      tx_ready_ff <= nxt_cnt < need_bits(nxt_cmode);
    end
  end

  // Phase change of phi1, differential on the reference phase
  always_comb
  begin
    case (cmode_ff)
      dsss_tx_pkg::mode_dbpsk: dphi = {bitbuf_ff[0], 1'b0};
      default: dphi = gray_phase(bitbuf_ff[0], bitbuf_ff[1]);
    endcase
    if ((cmode_ff == dsss_tx_pkg::mode_cck5 || cmode_ff == dsss_tx_pkg::mode_cck11) && cpay_ff && odd_ff)
      dphi = dphi + 2'h2;
    if (tx_reverse_ff)
      dphi = 2'h0 - dphi;
    nxt_ref = ref_ff + dphi;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff <= dsss_tx_pkg::st_idle;
      smode_ff <= dsss_tx_pkg::mode_dbpsk;
      chip_idx_ff <= 4'h0;
      ref_ff <= 2'h0;
      phi2_ff <= 2'h0;
      phi3_ff <= 2'h0;
      phi4_ff <= 2'h0;
      odd_ff <= 1'b0;
      iq_pair_ff <= 2'h0;
    end
    else
    begin
      case (state_ff)
        dsss_tx_pkg::st_idle:
        begin
          if (load_sym)
            state_ff <= dsss_tx_pkg::st_run;
        end
        dsss_tx_pkg::st_run:
        begin
          if (chip_en_ff)
            chip_idx_ff <= chip_idx_ff + 4'h1;
          if (last_chip && !load_sym)
            state_ff <= dsss_tx_pkg::st_idle;
        end
        default: state_ff <= dsss_tx_pkg::st_idle;
      endcase
      if (tx_start)
        odd_ff <= 1'b0;
      if (load_sym)
      begin
        smode_ff <= cmode_ff;
        chip_idx_ff <= 4'h0;
        ref_ff <= nxt_ref;
        iq_pair_ff <= quad_i_q(nxt_ref);
        if (cmode_ff == dsss_tx_pkg::mode_cck5)
        begin
          phi2_ff <= {bitbuf_ff[2], 1'b1};
          phi3_ff <= 2'h0;
          phi4_ff <= {bitbuf_ff[3], 1'b0};
        end
        else
        begin
          phi2_ff <= {bitbuf_ff[2], bitbuf_ff[3]};
          phi3_ff <= {bitbuf_ff[4], bitbuf_ff[5]};
          phi4_ff <= {bitbuf_ff[6], bitbuf_ff[7]};
        end
        odd_ff <= cpay_ff ? ~odd_ff : 1'b0;
      end
    end
  end

  // CCK chip phase; index 0 leaves first
  always_comb
  begin
    ci = chip_idx_ff[2:0];
    chip_phase = ref_ff;
    if (!ci[0])
      chip_phase = chip_phase + phi2_ff;
    if (!ci[1])
      chip_phase = chip_phase + phi3_ff;
    if (!ci[2])
      chip_phase = chip_phase + phi4_ff;
    if (ci == 3'h3 || ci == 3'h6)
      chip_phase = chip_phase + 2'h2;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      chip_ff <= '0;
    else if (chip_en_ff && state_ff == dsss_tx_pkg::st_run)
    begin
      chip_ff.valid <= 1'b1;
      if (smode_ff == dsss_tx_pkg::mode_cck5 || smode_ff == dsss_tx_pkg::mode_cck11)
        {chip_ff.i, chip_ff.q} <= quad_i_q(chip_phase);
      else
        {chip_ff.i, chip_ff.q} <= iq_pair_ff ^ {2{~dsss_tx_pkg::barker_word[chip_idx_ff]}};
    end
    else
      chip_ff.valid <= 1'b0;
  end

  // Receive descrambler, feedforward so it self-synchronizes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dscr_ff <= 7'h00;
      rx_data_ff <= 1'b0;
      rx_data_valid_ff <= 1'b0;
    end
    else
    begin
      rx_data_valid_ff <= rx_valid;
      if (rx_valid)
      begin
        dscr_ff <= {dscr_ff[5:0], rx_bit};
        rx_data_ff <= scr_bypass_ff ? rx_bit : rx_bit ^ dscr_ff[dsss_tx_pkg::tap_a] ^ dscr_ff[dsss_tx_pkg::tap_b];
      end
    end
  end

endmodule : dsss_scrambler_cck_modulator

/* File: verif/dsss_tx_checker_props.sv */
`timescale 1ns/1ps
module dsss_tx_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire dsss_tx_pkg::chip_t tx_chip,
  input wire logic rx_bit,
  input wire logic rx_valid,
  input wire logic rx_data,
  input wire logic rx_data_valid,
  input wire logic rx_rotate_reverse
);
  logic wr_cfg_ff, wr_ctl_ff, byp_ff, take, descr_bit, rev_bit;
  logic [6:0] hist_ff;
  logic [2:0] cnt_ff;
  logic [4:0] gap_ff;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign take = hsel && hready && htrans[1] && hwrite;
  // Own taps, so a wrong tap constant in the design still shows
  assign descr_bit = rx_bit ^ hist_ff[3] ^ hist_ff[6];
  assign rev_bit = hwdata[7];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_cfg_ff <= 1'b0;
      wr_ctl_ff <= 1'b0;
    end
    else
    begin
      wr_cfg_ff <= take && haddr[7:0] == dsss_tx_pkg::modem_config_off;
      wr_ctl_ff <= take && haddr[7:0] == dsss_tx_pkg::scrambler_control_off;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      byp_ff <= 1'b0;
    else if (wr_ctl_ff)
      byp_ff <= hwdata[2];
  end
  // Restart sync count on a bypass change, descrambler may hold stale bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hist_ff <= 7'h00;
      cnt_ff <= 3'h0;
    end
    else if (wr_ctl_ff)
      cnt_ff <= 3'h0;
    else if (rx_valid)
    begin
      hist_ff <= {hist_ff[5:0], rx_bit};
      cnt_ff <= (cnt_ff == 3'h7) ? cnt_ff : cnt_ff + 3'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gap_ff <= 5'h1F;
    else if (tx_chip.valid)
      gap_ff <= 5'h00;
    else if (gap_ff != 5'h1F)
      gap_ff <= gap_ff + 5'h01;
  end
  property p_resp_okay;
    hresp == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("slave response not OKAY");
  property p_ready;
    $past(hresetn) |-> hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_rx_pulse;
    rx_data_valid == $past(rx_valid);
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx valid not one cycle after input");
  property p_descramble;
    rx_valid && !byp_ff && cnt_ff == 3'h7 |=> rx_data == $past(descr_bit);
  endproperty
  a_descramble: assert property (p_descramble) else $error("descrambled bit wrong");
  property p_bypass;
    rx_valid && byp_ff |=> rx_data == $past(rx_bit);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed bit changed");
  property p_cfg_rev;
    wr_cfg_ff |=> rx_rotate_reverse == $past(rev_bit);
  endproperty
  a_cfg_rev: assert property (p_cfg_rev) else $error("rx reverse not written");
  property p_cfg_hold;
    !wr_cfg_ff |=> $stable(rx_rotate_reverse);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("rx reverse changed unasked");
  property p_chip_pulse;
    tx_chip.valid |=> !tx_chip.valid;
  endproperty
  a_chip_pulse: assert property (p_chip_pulse) else $error("chip valid longer than a cycle");
  property p_chip_gap;
    tx_chip.valid |-> gap_ff >= 5'h15;
  endproperty
  a_chip_gap: assert property (p_chip_gap) else $error("chips faster than chip rate");
  c_chip: cover property (tx_chip.valid);
  c_byp: cover property (rx_valid && byp_ff);
  c_descr: cover property (rx_valid && !byp_ff && cnt_ff == 3'h7);
  c_cfg: cover property (wr_cfg_ff);
endmodule : dsss_tx_checker

bind dsss_scrambler_cck_modulator dsss_tx_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .tx_chip(tx_chip),
  .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
  .rx_rotate_reverse(rx_rotate_reverse)
);

/* File: verif/tx_far_end.sv */
`timescale 1ns/1ps
module tx_far_end (
  input wire logic hclk,
  input wire logic tx_ready,
  input wire dsss_tx_pkg::chip_t tx_chip,
  output logic tx_bit,
  output logic tx_valid
);
  logic bits[$];
  logic [1:0] ph[$];
  initial
  begin
    tx_bit = 1'b0;
    tx_valid = 1'b0;
  end
  // Idle data line toggles so a stale bit is never mistaken for data
  always @(posedge hclk)
  begin
    if (tx_valid && tx_ready)
      void'(bits.pop_front());
    tx_valid <= bits.size() > 0;
    tx_bit <= (bits.size() > 0) ? bits[0] : ~tx_bit;
    if (tx_chip.valid)
      ph.push_back({~tx_chip.q, tx_chip.i ^ tx_chip.q});
  end
endmodule : tx_far_end

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
  // Barker chips sent as -1, chip 0 in bit 0
  localparam logic [10:0] neg_chips = 11'h712;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic tx_start = 1'b0;
  logic rx_bit = 1'b0;
  logic rx_valid = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [1:0] tx_seg = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic [15:0] pat;
  logic sb[16];
  logic hreadyout, hresp, tx_ready, tx_bit, tx_valid, rx_data, rx_data_valid, rx_rotate_reverse, tx_active;
  logic [1:0] last_ph = 2'h0;
  dsss_tx_pkg::chip_t tx_chip;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  always #2 hclk = ~hclk;
  dsss_scrambler_cck_modulator dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_start(tx_start), .tx_seg(tx_seg), .tx_bit(tx_bit), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_chip(tx_chip), .tx_active(tx_active), .rx_bit(rx_bit), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_data_valid(rx_data_valid), .rx_rotate_reverse(rx_rotate_reverse)
  );
  tx_far_end far (.hclk(hclk), .tx_ready(tx_ready), .tx_chip(tx_chip), .tx_bit(tx_bit), .tx_valid(tx_valid));
  task stop_test;
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task reg_test;
    ahb(1'b0, dsss_tx_pkg::long_seed_off, 32'h0);
    check(rd === 32'h0000007F, "long seed reset value");
    ahb(1'b0, dsss_tx_pkg::short_seed_off, 32'h0);
    check(rd === 32'h0000007F, "short seed reset value");
    ahb(1'b1, 8'h40, 32'hFFFFFFFF);
    ahb(1'b0, 8'h40, 32'h0);
    check(rd === 32'h0, "unmapped read not zero");
    ahb(1'b1, dsss_tx_pkg::modem_config_off, 32'h00000080);
    ahb(1'b0, dsss_tx_pkg::modem_config_off, 32'h0);
    check(rd[7:6] === 2'h2 && rx_rotate_reverse === 1'b1, "rx reverse not set");
    ahb(1'b1, dsss_tx_pkg::modem_config_off, 32'h0);
    ahb(1'b0, dsss_tx_pkg::modem_config_off, 32'h0);
    check(rd === 32'h0 && rx_rotate_reverse === 1'b0, "rx reverse not cleared");
  endtask : reg_test
  task rx_run(input logic byp);
    logic [6:0] s;
    logic e;
    s = 7'h55;
    for (int k = 0; k < 16; k++)
    begin
      e = pat[k] ^ s[3] ^ s[6];
      s = {s[5:0], e};
      @(posedge hclk);
      rx_valid <= 1'b1;
      rx_bit <= byp ? pat[k] : e;
      @(posedge hclk);
      rx_valid <= 1'b0;
      rx_bit <= ~rx_bit;
      #1;
      check(rx_data_valid === 1'b1 && ((k < 7 && !byp) || rx_data === pat[k]), "rx bit wrong");
    end
  endtask : rx_run
  task send(input logic [1:0] seg, input int n, input int nchips, input logic byp, input logic [6:0] seed);
    logic [6:0] s;
    int t;
    s = seed;
    t = 0;
    if (far.ph.size() > 0)
      last_ph = far.ph[far.ph.size() - 1];
    far.ph.delete();
    @(posedge hclk);
    tx_start <= 1'b1;
    tx_seg <= seg;
    @(posedge hclk);
    tx_start <= 1'b0;
    for (int k = 0; k < n; k++)
    begin
      sb[k] = byp ? pat[k] : pat[k] ^ s[3] ^ s[6];
      s = {s[5:0], sb[k]};
      far.bits.push_back(pat[k]);
    end
    while (far.ph.size() == 0) @(posedge hclk);
    check(tx_active === 1'b1, "not active while sending");
    while (far.ph.size() < nchips)
    begin
      @(posedge hclk);
      t++;
    end
    check(tx_active === 1'b0, "still active after last chip");
    check(t * dsss_tx_pkg::div_step >= (nchips - 1) * dsss_tx_pkg::div_mod - 44, "chips too fast");
    check(t * dsss_tx_pkg::div_step <= (nchips - 1) * dsss_tx_pkg::div_mod + 44, "chips too slow");
  endtask : send
  task chk_barker(input int nsym, input logic dq, input logic rev);
    logic [1:0] base, prev, dexp;
    prev = 2'h0;
    for (int k = 0; k < nsym; k++)
    begin
      base = far.ph[11 * k];
      for (int j = 0; j < 11; j++)
        check(far.ph[11 * k + j] === base + {neg_chips[j], 1'b0}, "barker chip wrong");
      dexp = dq ? {sb[2 * k], sb[2 * k] ^ sb[2 * k + 1]} : {sb[k], 1'b0};
      if (rev)
        dexp = 2'h0 - dexp;
      if (!dq) check(base[0] === 1'b0, "i and q differ");
      if (k > 0) check(base - prev === dexp, "symbol phase step wrong");
      prev = base;
    end
  endtask : chk_barker
  task chk_cck(input logic c5);
    logic [1:0] p2, p3, p4, r7;
    logic [1:0] e[8];
    int nb;
    nb = c5 ? 4 : 8;
    if (c5)
      check(far.ph[7] - last_ph === {sb[0], sb[0] ^ sb[1]}, "first symbol reference wrong");
    for (int m = 0; m < 2; m++)
    begin
      p2 = c5 ? {sb[nb * m + 2], 1'b1} : {sb[nb * m + 2], sb[nb * m + 3]};
      p3 = c5 ? 2'h0 : {sb[nb * m + 4], sb[nb * m + 5]};
      p4 = c5 ? {sb[nb * m + 3], 1'b0} : {sb[nb * m + 6], sb[nb * m + 7]};
      e = '{p2 + p3 + p4, p3 + p4, p2 + p4, p4 + 2'h2, p2 + p3, p3, p2 + 2'h2, 2'h0};
      r7 = far.ph[8 * m + 7];
      for (int j = 0; j < 8; j++)
        check(far.ph[8 * m + j] - r7 === e[j], "cck chip wrong");
    end
    check(far.ph[15] - far.ph[7] === {sb[nb], sb[nb] ^ sb[nb + 1]} + 2'h2, "odd symbol phase wrong");
  endtask : chk_cck
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 15000)
    begin
      n_errors++;
      stop_test();
    end
  end
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reg_test();
    pat = 16'hC5A3;
    rx_run(1'b0);
    ahb(1'b1, dsss_tx_pkg::scrambler_control_off, 32'h00000004);
    rx_run(1'b1);
    send(dsss_tx_pkg::seg_preamble, 8, 88, 1'b1, 7'h7F);
    chk_barker(8, 1'b0, 1'b0);
    ahb(1'b1, dsss_tx_pkg::scrambler_control_off, 32'h0);
    send(dsss_tx_pkg::seg_preamble, 12, 132, 1'b0, 7'h7F);
    chk_barker(12, 1'b0, 1'b0);
    ahb(1'b1, dsss_tx_pkg::tx_setup_off, 32'h00000001);
    send(dsss_tx_pkg::seg_payload, 8, 44, 1'b0, 7'h7F);
    chk_barker(4, 1'b1, 1'b0);
    ahb(1'b1, dsss_tx_pkg::short_seed_off, 32'h0000001B);
    ahb(1'b1, dsss_tx_pkg::modem_config_off, 32'h00000040);
    ahb(1'b1, dsss_tx_pkg::tx_setup_off, 32'h00000004);
    send(dsss_tx_pkg::seg_header, 8, 44, 1'b0, 7'h1B);
    chk_barker(4, 1'b1, 1'b1);
    ahb(1'b1, dsss_tx_pkg::modem_config_off, 32'h0);
    ahb(1'b1, dsss_tx_pkg::tx_setup_off, 32'h00000003);
    send(dsss_tx_pkg::seg_payload, 16, 16, 1'b0, 7'h7F);
    chk_cck(1'b0);
    ahb(1'b1, dsss_tx_pkg::tx_setup_off, 32'h00000002);
    send(dsss_tx_pkg::seg_payload, 8, 16, 1'b0, 7'h7F);
    chk_cck(1'b1);
    stop_test();
  end
endmodule : tb
